// ---- feat_cfg_pkg.sv ----
package feat_cfg_pkg;
	// ==========================================================
	// Command codes and feature addresses
	localparam logic [7:0] CMD_SET_FEAT = 8'hEF;
	localparam logic [7:0] CMD_GET_FEAT = 8'hEE;
	localparam logic [7:0] FA_TIMING = 8'h01;
	localparam logic [7:0] FA_DRIVE = 8'h80;
	localparam logic [7:0] FA_RBPULL = 8'h81;
	localparam logic [7:0] FA_ARRAY = 8'h90;
	localparam logic [7:0] ARRAY_MASK = 8'h0B;
	localparam logic [7:0] ECC_ON_VAL = 8'h08;
	localparam logic [2:0] TMODE_MAX = 3'h5;
	localparam logic [2:0] TMODE_LOW_SUPPLY_MAX = 3'h4;
	localparam int ECC_BIT = 3;
	// ==========================================================
	// Software register map (byte addresses)
	localparam int ADDR_W = 8;
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_FADDR = 8'h04;
	localparam logic [7:0] REG_PWR = 8'h08;
	localparam logic [7:0] REG_PRD = 8'h0C;
	localparam logic [7:0] REG_STAT = 8'h10;
	localparam logic [7:0] REG_CFG = 8'h14;
	localparam int CTRL_SET_BIT = 0;
	localparam int CTRL_GET_BIT = 1;
	localparam int CTRL_CLR_BIT = 2;
	localparam int CFG_HS_BIT = 0;
	localparam logic [7:0] FADDR_RST = 8'h00;
	localparam logic [31:0] PARAM_RST = 32'h0000_0000;
	// ==========================================================
	// Timing, 40 MHz reference
	localparam int CLK_NS = 25;
	localparam int SETUP_NS = 50;
	localparam int WLOW_NS = 50;
	localparam int WHIGH_NS = 50;
	localparam int ADL_NS = 200;
	localparam int WB_NS = 100;
	localparam int RLOW_NS = 200;
	localparam int RHIGH_NS = 50;
	localparam int FEAT_NS = 1000;
	localparam int ITC_NS = 5000;
	localparam logic [15:0] SETUP_CYC = 16'((SETUP_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [15:0] WLOW_CYC = 16'((WLOW_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [15:0] WHIGH_CYC = 16'((WHIGH_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [15:0] WR_CYC = 16'(SETUP_CYC + WLOW_CYC + WHIGH_CYC);
	localparam logic [15:0] ADL_CYC = 16'((ADL_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [15:0] WB_CYC = 16'((WB_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [15:0] RLOW_CYC = 16'((RLOW_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [15:0] RD_CYC = 16'(RLOW_CYC + (RHIGH_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [15:0] FEAT_CYC = 16'((FEAT_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [15:0] ITC_CYC = 16'((ITC_NS + CLK_NS - 1) / CLK_NS);
	// ==========================================================
	// Sequencer states
	typedef enum logic [7:0] {
		S_IDLE = 8'h01,
		S_CMD = 8'h02,
		S_ADDR = 8'h04,
		S_ADL = 8'h08,
		S_DIN = 8'h10,
		S_WB = 8'h20,
		S_BUSY = 8'h40,
		S_DOUT = 8'h80
	} seq_state_t;
endpackage

// ---- pin_sync.sv ----
`timescale 1ns/1ps
module pin_sync #(
	parameter int W = 9
) (
	input wire logic ref_clk_i,
	input wire logic reset_n_i,
	input wire logic [W-1:0] pin_i,
	output logic [W-1:0] pin_o
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] q;
	} sync_t;
	sync_t s;
	sync_t next_s;
	genvar g;

	// ==========================================================
	// Per bit, a change counts once stages two and three agree
	generate
		for (g = 0; g < W; g++)
		begin : g_bit
			always_comb
			begin
				next_s.s1[g] = pin_i[g];
				next_s.s2[g] = s.s1[g];
				next_s.s3[g] = s.s2[g];
				next_s.q[g] = (s.s2[g] == s.s3[g]) ? s.s3[g] : s.q[g];
			end
		end
	endgenerate

	always_ff @(posedge ref_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			s <= '0;
		else
			s <= next_s;
	end

	assign pin_o = s.q;
endmodule

// ---- feat_cfg_host.sv ----
`timescale 1ns/1ps
module feat_cfg_host (
	input wire logic ref_clk_i,
	input wire logic reset_n_i,
	input wire logic [feat_cfg_pkg::ADDR_W-1:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_stb_i,
	input wire logic rd_stb_i,
	output logic [31:0] rdata_o,
	output logic ce_n_o,
	output logic cle_o,
	output logic ale_o,
	output logic we_n_o,
	output logic re_n_o,
	output logic [7:0] io_o,
	output logic io_oe_n_o,
	input wire logic [7:0] io_i,
	input wire logic rb_n_i
);
	import feat_cfg_pkg::*;
	typedef struct packed {
		seq_state_t st;
		logic [15:0] cnt;
		logic [1:0] idx;
		logic is_get;
		logic pend;
		logic hs;
		logic done;
		logic tout;
		logic [7:0] faddr;
		logic [31:0] pwr;
		logic [31:0] prd;
		logic [31:0] rdata;
		logic ce_n;
		logic cle;
		logic ale;
		logic we_n;
		logic re_n;
		logic [7:0] io;
		logic oe_n;
		logic din;
		logic [1:0] din_idx;
		logic [7:0] since_addr;
	} host_state_t;
	host_state_t s;
	host_state_t next_s;
	logic [8:0] pins_s;
	logic rb_ready;
	logic [7:0] io_s;
	logic wr_phase;
	logic wr_end;
	logic [15:0] busy_limit;

	pin_sync #(
		.W(9)
	) u_sync (
		.ref_clk_i(ref_clk_i),
		.reset_n_i(reset_n_i),
		.pin_i({rb_n_i, io_i}),
		.pin_o(pins_s)
	);

	assign rb_ready = pins_s[8];
	assign io_s = pins_s[7:0];

	// ==========================================================
	// First parameter shaping: reserved bits forced to zero for the four known feature addresses, other addresses pass unchanged
	function automatic logic [7:0] shape_p1(input logic [7:0] fa, input logic [7:0] b,
		input logic hs);
		logic [2:0] m;
		m = b[2:0];
		shape_p1 = b;
		case (fa)
			FA_TIMING:
			begin
				if (m > TMODE_MAX)
					m = TMODE_MAX;
				if (m == TMODE_MAX && !hs)
					m = TMODE_LOW_SUPPLY_MAX;
				shape_p1 = {5'h00, m};
			end
			FA_DRIVE, FA_RBPULL:
				shape_p1 = {6'h00, b[1:0]};
			FA_ARRAY:
				shape_p1 = b & ARRAY_MASK;
			default:
				shape_p1 = b;
		endcase
	endfunction

	// ==========================================================
	// Next-state logic
	always_comb
	begin
		next_s = s;
		next_s.rdata = 32'h0000_0000;
		wr_phase = (s.cnt >= SETUP_CYC) && (s.cnt < 16'(SETUP_CYC + WLOW_CYC));
		wr_end = (s.cnt == 16'(WR_CYC - 16'h0001));
		// Interface change may take longer than a plain feature write
		busy_limit = (!s.is_get && s.faddr == FA_TIMING) ? ITC_CYC : FEAT_CYC;
		if (rd_stb_i)
		begin
			case (addr_i)
				REG_CTRL: next_s.rdata = {31'h0000_0000, s.is_get};
				REG_FADDR: next_s.rdata = {24'h00_0000, s.faddr};
				REG_PWR: next_s.rdata = s.pwr;
				REG_PRD: next_s.rdata = s.prd;
				REG_STAT: next_s.rdata = {28'h000_0000, s.tout, s.done,
					(s.pend || s.st != S_IDLE), rb_ready};
				REG_CFG: next_s.rdata = {31'h0000_0000, s.hs};
				default: next_s.rdata = 32'h0000_0000;
			endcase
		end
		// Parameters and address are frozen while a transfer is under way
		if (wr_stb_i && s.st == S_IDLE && !s.pend)
		begin
			case (addr_i)
				REG_FADDR: next_s.faddr = wdata_i[7:0];
				REG_PWR: next_s.pwr = wdata_i;
				REG_CFG: next_s.hs = wdata_i[CFG_HS_BIT];
				REG_CTRL:
				begin
					if (wdata_i[CTRL_SET_BIT] || wdata_i[CTRL_GET_BIT])
					begin
						next_s.pend = 1'b1;
						next_s.is_get = wdata_i[CTRL_GET_BIT] && !wdata_i[CTRL_SET_BIT];
						next_s.done = 1'b0;
						next_s.tout = 1'b0;
					end
				end
				default: next_s.pend = s.pend;
			endcase
		end
		// Clear comes first so that a completion in the same cycle wins
		if (wr_stb_i && addr_i == REG_CTRL && wdata_i[CTRL_CLR_BIT])
		begin
			next_s.done = 1'b0;
			next_s.tout = 1'b0;
		end
		next_s.since_addr = s.ale ? 8'h00 :
			(s.since_addr == 8'hFF ? 8'hFF : 8'(s.since_addr + 8'h01));
		next_s.ce_n = (s.st == S_IDLE);
		next_s.cle = 1'b0;
		next_s.ale = 1'b0;
		next_s.we_n = 1'b1;
		next_s.re_n = 1'b1;
		next_s.oe_n = 1'b1;
		next_s.din = 1'b0;
		next_s.din_idx = s.idx;
		case (s.st)
			S_IDLE:
			begin
				next_s.cnt = 16'h0000;
				if (s.pend && rb_ready)
				begin
					next_s.pend = 1'b0;
					next_s.st = S_CMD;
				end
			end
			S_CMD:
			begin
				next_s.cle = 1'b1;
				next_s.oe_n = 1'b0;
				next_s.io = s.is_get ? CMD_GET_FEAT : CMD_SET_FEAT;
				next_s.we_n = !wr_phase;
				next_s.cnt = wr_end ? 16'h0000 : 16'(s.cnt + 16'h0001);
				if (wr_end)
					next_s.st = S_ADDR;
			end
			S_ADDR:
			begin
				next_s.ale = 1'b1;
				next_s.oe_n = 1'b0;
				next_s.io = s.faddr;
				next_s.we_n = !wr_phase;
				next_s.cnt = wr_end ? 16'h0000 : 16'(s.cnt + 16'h0001);
				if (wr_end)
					next_s.st = s.is_get ? S_WB : S_ADL;
			end
			S_ADL:
			begin
				next_s.cnt = 16'(s.cnt + 16'h0001);
				next_s.idx = 2'h0;
				if (s.cnt == 16'(ADL_CYC - 16'h0001))
				begin
					next_s.cnt = 16'h0000;
					next_s.st = S_DIN;
				end
			end
			S_DIN:
			begin
				next_s.oe_n = 1'b0;
				next_s.din = 1'b1;
				next_s.io = (s.idx == 2'h0) ? shape_p1(s.faddr, s.pwr[7:0], s.hs) : 8'h00;
				next_s.we_n = !wr_phase;
				next_s.cnt = wr_end ? 16'h0000 : 16'(s.cnt + 16'h0001);
				if (wr_end)
				begin
					next_s.idx = 2'(s.idx + 2'h1);
					if (s.idx == 2'h3)
						next_s.st = S_WB;
				end
			end
			S_WB:
			begin
				next_s.cnt = 16'(s.cnt + 16'h0001);
				if (s.cnt == 16'(WB_CYC - 16'h0001))
				begin
					next_s.cnt = 16'h0000;
					next_s.st = S_BUSY;
				end
			end
			S_BUSY:
			begin
				// Ready is watched on the busy pin, so no status read is ever
				// issued and data output needs no re-enable afterwards
				next_s.cnt = 16'(s.cnt + 16'h0001);
				next_s.idx = 2'h0;
				if (rb_ready)
				begin
					next_s.cnt = 16'h0000;
					next_s.st = s.is_get ? S_DOUT : S_IDLE;
					next_s.done = !s.is_get;
				end
				else if (s.cnt == 16'(busy_limit - 16'h0001))
				begin
					next_s.st = S_IDLE;
					next_s.tout = 1'b1;
					next_s.done = 1'b1;
				end
			end
			S_DOUT:
			begin
				next_s.re_n = !(s.cnt < RLOW_CYC);
				// Late sample hides the three-stage pin delay
				if (s.cnt == 16'(RLOW_CYC - 16'h0001))
					next_s.prd[{s.idx, 3'h0} +: 8] = io_s;
				next_s.cnt = 16'(s.cnt + 16'h0001);
				if (s.cnt == 16'(RD_CYC - 16'h0001))
				begin
					next_s.cnt = 16'h0000;
					next_s.idx = 2'(s.idx + 2'h1);
					if (s.idx == 2'h3)
					begin
						next_s.st = S_IDLE;
						next_s.done = 1'b1;
					end
				end
			end
			default:
				next_s.st = S_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			s <= '0;
			s.st <= S_IDLE;
			s.faddr <= FADDR_RST;
			s.pwr <= PARAM_RST;
			s.prd <= PARAM_RST;
			s.ce_n <= 1'b1;
			s.we_n <= 1'b1;
			s.re_n <= 1'b1;
			s.oe_n <= 1'b1;
			s.since_addr <= 8'hFF;
		end
		else
			s <= next_s;
	end

	assign rdata_o = s.rdata;
	assign ce_n_o = s.ce_n;
	assign cle_o = s.cle;
	assign ale_o = s.ale;
	assign we_n_o = s.we_n;
	assign re_n_o = s.re_n;
	assign io_o = s.io;
	assign io_oe_n_o = s.oe_n;

	// ==========================================================
	// Checks
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (!reset_n_i);

	AST_CMD_CODE: assert property ((s.cle && !s.we_n) |->
		(s.io == CMD_SET_FEAT || s.io == CMD_GET_FEAT) && !s.oe_n && !s.ce_n)
		else $error("bad command code on bus");
	AST_ADDR_BYTE: assert property ($rose(s.ale) |-> s.io == s.faddr ##1 s.ale)
		else $error("address byte differs from feature address");
	AST_RESERVED_ZERO: assert property ((s.din && s.din_idx != 2'h0) |-> s.io == 8'h00)
		else $error("reserved parameter byte not zero");
	AST_ADL_GAP: assert property ((s.din && $fell(s.we_n)) |-> s.since_addr >= 8'(ADL_CYC))
		else $error("parameter sent before address-to-data delay");
	AST_IDLE_START: assert property ($fell(s.ce_n) |-> $past(rb_ready, 2))
		else $error("feature command started while device busy");
	AST_READ_READY: assert property ($fell(s.re_n) |-> rb_ready)
		else $error("data read while device busy");
	AST_ECC_ON: assert property ((s.din && s.din_idx == 2'h0 && s.faddr == FA_ARRAY &&
		s.pwr[7:0] == ECC_ON_VAL) |-> s.io == ECC_ON_VAL)
		else $error("ecc enable value not sent");
	AST_ECC_OFF: assert property ((s.din && s.din_idx == 2'h0 && s.faddr == FA_ARRAY &&
		!s.pwr[ECC_BIT]) |-> !s.io[ECC_BIT] && s.io[7:4] == 4'h0)
		else $error("ecc disable sent with ecc bit set");
	AST_MODE_SUPPLY: assert property ((s.din && s.din_idx == 2'h0 && s.faddr == FA_TIMING)
		|-> s.io[2:0] <= TMODE_MAX && (s.hs || s.io[2:0] != TMODE_MAX))
		else $error("timing mode not allowed at this supply");
	AST_WE_PULSE: assert property ($fell(s.we_n) |-> !s.we_n [*2] ##1 s.we_n [*2])
		else $error("write strobe pulse shape wrong");

	COV_SET_DONE: cover property ($rose(s.done) && !s.is_get && !s.tout);
	COV_GET_DONE: cover property ($rose(s.done) && s.is_get && !s.tout);
	COV_TIMEOUT: cover property ($rose(s.tout));
	COV_ECC_ON: cover property (s.din && s.faddr == FA_ARRAY && s.io == ECC_ON_VAL);
endmodule

// ---- nand_feat_model.sv ----
`timescale 1ns/1ps
module nand_feat_model (
	input wire logic pwr_n_i,
	input wire logic slow_i,
	input wire logic ce_n_i,
	input wire logic cle_i,
	input wire logic ale_i,
	input wire logic we_n_i,
	input wire logic re_n_i,
	input wire logic [7:0] io_i,
	output logic [7:0] io_o,
	output logic rb_n_o
);
	import feat_cfg_pkg::*;
	// ==========================================================
	// Feature store and busy timing
	localparam int FEAT_BUSY_NS = 400;
	localparam int SLOW_BUSY_NS = 2500;
	localparam int ITC_BUSY_NS = 2000;
	logic [7:0] feat [4][4] = '{default: 8'h00};
	logic [7:0] stage [4];
	logic [7:0] fad = 8'h00;
	logic [7:0] last = 8'h00;
	logic [7:0] rbyte;
	logic [1:0] mode = 2'd0;
	int idx = 0;
	int busy_ns = 0;
	event go_busy;
	function automatic int slot(input logic [7:0] a);
		case (a)
			FA_TIMING: return 0;
			FA_DRIVE: return 1;
			FA_RBPULL: return 2;
			FA_ARRAY: return 3;
			default: return -1;
		endcase
	endfunction
	// Reserved bits and bytes are dropped, so they read back as zero
	function automatic logic [7:0] keep(input int s, input int i, input logic [7:0] v);
		if (i != 0)
			return 8'h00;
		case (s)
			0: return v & 8'h07;
			1, 2: return v & 8'h03;
			3: return v & 8'h0B;
			default: return 8'h00;
		endcase
	endfunction
	initial rb_n_o = 1'b1;
	always @(go_busy)
	begin
		rb_n_o = 1'b0;
		#(busy_ns);
		rb_n_o = 1'b1;
	end
	// ==========================================================
	// Command, address and parameter latching on strobe rising edges
	always @(posedge we_n_i or negedge pwr_n_i)
	begin
		if (!pwr_n_i)
		begin
			feat = '{default: 8'h00};
			mode = 2'd0;
		end
		else if (!ce_n_i && rb_n_o)
		begin
			if (cle_i)
			begin
				mode = (io_i == CMD_SET_FEAT) ? 2'd1 : (io_i == CMD_GET_FEAT) ? 2'd2 : 2'd0;
				idx = 0;
			end
			else if (ale_i && mode != 2'd0)
			begin
				fad = io_i;
				idx = 0;
				if (mode == 2'd2)
				begin
					busy_ns = FEAT_BUSY_NS;
					->go_busy;
				end
			end
			else if (mode == 2'd1 && idx < 4)
			begin
				stage[idx] = io_i;
				idx++;
				if (idx == 4)
				begin
					busy_ns = slow_i ? SLOW_BUSY_NS : FEAT_BUSY_NS;
					if (slot(fad) == 0 && keep(0, 0, stage[0]) != feat[0][0])
						busy_ns = ITC_BUSY_NS;
					if (slot(fad) >= 0)
						for (int i = 0; i < 4; i++)
							feat[slot(fad)][i] = keep(slot(fad), i, stage[i]);
					->go_busy;
				end
			end
		end
	end
	// ==========================================================
	// Read-back; an undriven bus shows the inverse of the last byte
	assign rbyte = (slot(fad) >= 0 && idx < 4) ? feat[slot(fad)][idx] : 8'h00;
	assign io_o = (!ce_n_i && !re_n_i && mode == 2'd2 && rb_n_o) ? rbyte : ~last;
	always @(posedge re_n_i)
		if (!ce_n_i && mode == 2'd2)
		begin
			last = rbyte;
			idx++;
		end
endmodule

// ---- nand_feature_config_handler_test.sv ----
`timescale 1ns/1ps
module nand_feature_config_handler_test;
	import feat_cfg_pkg::*;
	logic ref_clk = 1'b0;
	logic reset_n = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic wr_stb = 1'b0;
	logic rd_stb = 1'b0;
	logic pwr_n = 1'b1;
	logic slow = 1'b0;
	logic [31:0] rdata;
	logic [31:0] rv;
	logic [31:0] seed = 32'hFB01DF62;
	logic ce_n, cle, ale, we_n, re_n, oe_n, rb_n;
	logic [7:0] io_h, io_d, io_bus;
	logic [7:0] fa [5] = '{8'h01, 8'h80, 8'h81, 8'h90, 8'h02};
	logic [7:0] ra [4] = '{8'h04, 8'h08, 8'h0C, 8'h1C};
	int miscompares = 0;
	int n_checks = 0;
	// ==========================================================
	// Clock, bus resolution, instances
	always #12.5 ref_clk = ~ref_clk;
	assign io_bus = oe_n ? io_d : io_h;
	feat_cfg_host dut (.ref_clk_i(ref_clk), .reset_n_i(reset_n), .addr_i(addr), .wdata_i(wdata),
		.wr_stb_i(wr_stb), .rd_stb_i(rd_stb), .rdata_o(rdata), .ce_n_o(ce_n), .cle_o(cle),
		.ale_o(ale), .we_n_o(we_n), .re_n_o(re_n), .io_o(io_h), .io_oe_n_o(oe_n), .io_i(io_bus),
		.rb_n_i(rb_n));
	nand_feat_model part (.pwr_n_i(pwr_n), .slow_i(slow), .ce_n_i(ce_n), .cle_i(cle),
		.ale_i(ale), .we_n_i(we_n), .re_n_i(re_n), .io_i(io_bus), .io_o(io_d), .rb_n_o(rb_n));
	// ==========================================================
	// Helpers
	function logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	function automatic logic [31:0] shape(input logic [7:0] a, input logic [7:0] v, input logic hs);
		logic [7:0] r;
		r = 8'h00;
		if (a == FA_TIMING)
		begin
			r = (v[2:0] > TMODE_MAX) ? {5'h0, TMODE_MAX} : {5'h0, v[2:0]};
			if (r == 8'h05 && !hs)
				r = 8'h04;
		end
		else if (a == FA_DRIVE || a == FA_RBPULL)
			r = v & 8'h03;
		else if (a == FA_ARRAY)
			r = v & 8'h0B;
		return {24'h0, r};
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("ERROR %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		addr <= a;
		wdata <= d;
		wr_stb <= 1'b1;
		@(posedge ref_clk);
		wr_stb <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge ref_clk);
		addr <= a;
		rd_stb <= 1'b1;
		@(posedge ref_clk);
		rd_stb <= 1'b0;
		#1 d = rdata;
	endtask
	// Bounded poll: a hang shows up as a missing done bit
	task automatic wait_done(input logic to);
		int n;
		n = 0;
		rv = 32'h0;
		while (rv[2] !== 1'b1 && n < 3000)
		begin
			rd(REG_STAT, rv);
			n++;
		end
		check({30'h0, rv[3:2]}, {30'h0, to, 1'b1});
		wr(REG_CTRL, 32'h4);
	endtask
	task automatic op(input logic [7:0] a, input logic [7:0] p, input logic g, input logic to);
		wr(REG_FADDR, {24'h0, a});
		wr(REG_PWR, {24'h0, p});
		wr(REG_CTRL, g ? 32'h2 : 32'h1);
		wait_done(to);
	endtask
	task automatic get(input logic [7:0] a, input logic [31:0] e);
		op(a, 8'h00, 1'b1, 1'b0);
		rd(REG_PRD, rv);
		check(rv, e);
	endtask
	task automatic setget(input logic [7:0] a, input logic [7:0] p, input logic hs);
		wr(REG_CFG, {31'h0, hs});
		op(a, p, 1'b0, 1'b0);
		get(a, shape(a, p, hs));
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// ==========================================================
	// Tests
	initial
	begin
		logic [7:0] a;
		logic [7:0] v;
		repeat (3) @(posedge ref_clk);
		reset_n <= 1'b1;
		wr(8'h1C, 32'hFFFF_FFFF);
		foreach (ra[i])
		begin
			rd(ra[i], rv);
			check(rv, 32'h0);
		end
		$display("reset values done");
		wr(REG_FADDR, 32'h90);
		wr(REG_PWR, 32'h08);
		// Both start bits at once: set must win
		wr(REG_CTRL, 32'h3);
		wr(REG_FADDR, 32'h01);
		rd(REG_FADDR, rv);
		check(rv, 32'h90);
		rd(REG_STAT, rv);
		check({30'h0, rv[1:0]}, 32'h3);
		wait_done(1'b0);
		get(FA_ARRAY, 32'h08);
		rd(REG_CTRL, rv);
		check({31'h0, rv[0]}, 32'h1);
		setget(FA_ARRAY, 8'h00, 1'b0);
		setget(FA_ARRAY, 8'h01, 1'b0);
		$display("array mode done");
		setget(FA_TIMING, 8'h05, 1'b0);
		setget(FA_TIMING, 8'h05, 1'b1);
		setget(FA_TIMING, 8'h07, 1'b1);
		rd(REG_CFG, rv);
		check(rv, 32'h1);
		for (int i = 0; i < 12; i++)
		begin
			v = 8'(rnd());
			a = fa[rnd() % 5];
			setget(a, (a == FA_TIMING) ? (v & 8'h07) : v, v[7]);
		end
		$display("random features done");
		slow <= 1'b1;
		op(FA_DRIVE, 8'h02, 1'b0, 1'b1);
		slow <= 1'b0;
		setget(FA_DRIVE, 8'h01, 1'b0);
		wr(REG_FADDR, 32'h80);
		wr(REG_PWR, 32'h03);
		wr(REG_CTRL, 32'h1);
		repeat (10) @(posedge ref_clk);
		reset_n <= 1'b0;
		repeat (3) @(posedge ref_clk);
		reset_n <= 1'b1;
		get(FA_DRIVE, 32'h01);
		$display("timeout and abort done");
		pwr_n <= 1'b0;
		@(posedge ref_clk);
		pwr_n <= 1'b1;
		foreach (fa[i])
			get(fa[i], 32'h0);
		$display("power cycle done");
		close_out();
	end
	initial
	begin
		#1_000_000;
		miscompares++;
		close_out();
	end
endmodule
